// file: rtl/xdc_core.sv
// host expansion unit: port decode, bank decode, row/column memory sequencing and clock interrupt
//
// Contract
// - an I/O write gives drive select at 37E0, printer data at 37E8, nothing at 37E4 and disk writes at 37EC-37EF.
// - an I/O read at 37E0 returns clock status and clears the pending tick, 37E8 printer status, 37EC-37EF disk.
// - six strobes cover 37E0 to 37EC and the disk controller itself tells 37ED-37EF apart.
// - memory cycles are claimed only for addresses 8000 to FFFF.
// - the lower bank is enabled for 8000 to BFFF.
// - the upper bank is enabled for C000 to FFFF.
// - the top two address bits pick the bank and the low fourteen go multiplexed as row and column.
// - an access starts with the row/column select low, the seven row bits out and RAS low.
// - after the row the select rises, the seven column bits go out and then CAS falls.
// - after both strobes the memory writes or reads as its write enable says.
// - the read enable turns the memory data buffers toward the host only during reads.
// - a refresh pulses RAS alone, with no select and no CAS.
// - all 128 rows must be refreshed at least once every 2 ms.
// - the clock block raises an interrupt request every 25 ms.
`timescale 1ns/100ps
module xdc_core #(
  parameter int TICK_CYCLES = xdc_pkg::TICK_CYC
) (
  input  wire logic                          clock,
  input  wire logic                          nrst,
  input  wire logic                          ce,
  // host bus pins
  input  wire logic [xdc_pkg::ADDR_W-1:0]    host_addr,
  input  wire logic                          host_mem_rd_n,
  input  wire logic                          host_mem_wr_n,
  input  wire logic                          host_io_rd_n,
  input  wire logic                          host_io_wr_n,
  input  wire logic                          host_rfsh_n,
  output logic [xdc_pkg::DATA_W-1:0]         host_data_out,
  output logic                               host_data_oe_n,
  output logic                               host_nmi_n,
  // port strobes
  output logic                               drive_select_wr,
  output logic                               printer_data_wr,
  output logic                               printer_status_rd,
  output logic                               disk_wr,
  output logic                               disk_rd,
  output logic [1:0]                         disk_sub_addr,
  // memory side
  output logic                               lower_bank_enable,
  output logic                               upper_bank_enable,
  output logic [xdc_pkg::ROW_W-1:0]          dram_addr,
  output logic [1:0]                         dram_ras_n,
  output logic                               dram_cas_n,
  output logic                               row_col_select,
  output logic                               dram_we_n,
  output logic                               mem_read_enable,
  output logic                               refresh_late
);
  import xdc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true when the address falls in the given group of four of the sixteen peripheral ports
  function automatic logic port_hit(input logic [ADDR_W-1:0] a, input logic [1:0] grp);
    port_hit = ((a & PORT_MASK) == PORT_BASE) && (a[GRP_LSB +: 2] == grp);
  endfunction

  // seven address bits for the row or the column half
  function automatic logic [ROW_W-1:0] addr_half(input logic [ADDR_W-1:0] a, input logic col);
    addr_half = col ? a[COL_LSB +: ROW_W] : a[ROW_LSB +: ROW_W];
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;

  // host pins are asynchronous to this clock
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else if (ce) begin
      sync1_q <= {host_addr, host_mem_rd_n, host_mem_wr_n, host_io_rd_n, host_io_wr_n, host_rfsh_n};
      sync2_q <= sync1_q;
    end
  end

  logic [ADDR_W-1:0] addr_s;
  logic              mem_rd_s;
  logic              mem_wr_s;
  logic              io_rd_s;
  logic              io_wr_s;
  logic              rfsh_s;

  assign addr_s   = sync2_q[SYNC_W-1 -: ADDR_W];
  assign mem_rd_s = !sync2_q[4];
  assign mem_wr_s = !sync2_q[3];
  assign io_rd_s  = !sync2_q[2];
  assign io_wr_s  = !sync2_q[1];
  assign rfsh_s   = !sync2_q[0];

  // ----------------------------------------------------------------
  // memory claim and bank decode
  // ----------------------------------------------------------------
  logic mem_claim;
  logic mem_bank;

  // a refresh cycle is never a claimed access
  assign mem_claim = (mem_rd_s || mem_wr_s) && !rfsh_s && addr_s[ADDR_MEM_BIT];
  assign mem_bank  = addr_s[ADDR_BANK_BIT];

  logic lower_en_q;
  logic upper_en_q;

  // bank enables follow the decoded cycle as levels
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lower_en_q <= 1'b0;
      upper_en_q <= 1'b0;
    end else if (ce) begin
      lower_en_q <= mem_claim && !mem_bank;
      upper_en_q <= mem_claim && mem_bank;
    end
  end

  // ----------------------------------------------------------------
  // row / column sequencer
  // ----------------------------------------------------------------
  xdc_state_type     state_q;
  xdc_state_type     state_d;
  logic [ADDR_W-1:0] acc_addr_q;
  logic              acc_bank_q;
  logic              acc_write_q;

  // next state; refresh takes priority since it only comes between accesses
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (rfsh_s) begin
          state_d = ST_RFSH;
        end else if (mem_claim) begin
          state_d = ST_ROW;
        end
      end
      ST_ROW:     state_d = ST_COL_SEL;
      ST_COL_SEL: state_d = ST_CAS;
      ST_CAS: begin
        if (!mem_claim) begin
          state_d = ST_END;
        end
      end
      ST_RFSH: begin
        if (!rfsh_s) begin
          state_d = ST_END;
        end
      end
      ST_END:     state_d = ST_IDLE;
      default:    state_d = ST_IDLE;
    endcase
  end

  // state and the address held for the whole access
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q     <= ST_IDLE;
      acc_addr_q  <= '0;
      acc_bank_q  <= 1'b0;
      acc_write_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      if (state_q == ST_IDLE) begin
        acc_addr_q  <= addr_s;
        acc_bank_q  <= mem_bank;
        acc_write_q <= mem_wr_s;
      end
    end
  end

  logic [ROW_W-1:0] dram_addr_q;
  logic [1:0]       ras_n_q;
  logic             cas_n_q;
  logic             sel_q;
  logic             we_n_q;
  logic             rd_en_q;

  // strobes registered from the next state so they change cleanly together
  always_ff @(posedge clock) begin
    if (!nrst) begin
      dram_addr_q <= '0;
      ras_n_q     <= 2'h3;
      cas_n_q     <= 1'b1;
      sel_q       <= 1'b0;
      we_n_q      <= 1'b1;
      rd_en_q     <= 1'b0;
    end else if (ce) begin
      case (state_d)
        ST_ROW: begin
          dram_addr_q <= addr_half(addr_s, 1'b0);
          ras_n_q     <= mem_bank ? 2'h1 : 2'h2;
          cas_n_q     <= 1'b1;
          sel_q       <= 1'b0;
          we_n_q      <= !mem_wr_s;
          rd_en_q     <= 1'b0;
        end
        ST_COL_SEL: begin
          dram_addr_q <= addr_half(acc_addr_q, 1'b1);
          ras_n_q     <= acc_bank_q ? 2'h1 : 2'h2;
          cas_n_q     <= 1'b1;
          sel_q       <= 1'b1;
          we_n_q      <= !acc_write_q;
          rd_en_q     <= 1'b0;
        end
        ST_CAS: begin
          dram_addr_q <= addr_half(acc_addr_q, 1'b1);
          ras_n_q     <= acc_bank_q ? 2'h1 : 2'h2;
          cas_n_q     <= 1'b0;
          sel_q       <= 1'b1;
          we_n_q      <= !acc_write_q;
          rd_en_q     <= !acc_write_q;
        end
        ST_RFSH: begin
          // row comes from the host refresh counter on the bus
          dram_addr_q <= addr_half(addr_s, 1'b0);
          ras_n_q     <= 2'h0;
          cas_n_q     <= 1'b1;
          sel_q       <= 1'b0;
          we_n_q      <= 1'b1;
          rd_en_q     <= 1'b0;
        end
        default: begin
          // idle and precharge: every strobe released
          ras_n_q <= 2'h3;
          cas_n_q <= 1'b1;
          sel_q   <= 1'b0;
          we_n_q  <= 1'b1;
          rd_en_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // refresh watchdog
  // ----------------------------------------------------------------
  logic [REFRESH_CNT_W-1:0] gap_q;
  logic                     late_q;

  // 128 rows in 2 ms means one pulse per gap at least; flag sticks until a pulse arrives
  always_ff @(posedge clock) begin
    if (!nrst) begin
      gap_q  <= '0;
      late_q <= 1'b0;
    end else if (ce) begin
      if (state_d == ST_RFSH && state_q != ST_RFSH) begin
        gap_q  <= '0;
        late_q <= 1'b0;
      end else if (gap_q == REFRESH_CNT_W'(REFRESH_GAP_CYC)) begin
        late_q <= 1'b1;
      end else begin
        gap_q <= gap_q + REFRESH_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  logic drv_wr_q;
  logic prn_wr_q;
  logic prn_rd_q;
  logic dsk_wr_q;
  logic dsk_rd_q;
  logic clk_rd_q;
  logic [1:0] sub_q;

  // 37E4 (GRP_UNUSED) is not decoded to any strobe, so it has no output
  always_ff @(posedge clock) begin
    if (!nrst) begin
      drv_wr_q <= 1'b0;
      prn_wr_q <= 1'b0;
      prn_rd_q <= 1'b0;
      dsk_wr_q <= 1'b0;
      dsk_rd_q <= 1'b0;
      clk_rd_q <= 1'b0;
      sub_q    <= 2'h0;
    end else if (ce) begin
      drv_wr_q <= io_wr_s && port_hit(addr_s, GRP_CLOCK);
      prn_wr_q <= io_wr_s && port_hit(addr_s, GRP_PRINTER);
      dsk_wr_q <= io_wr_s && port_hit(addr_s, GRP_DISK);
      clk_rd_q <= io_rd_s && port_hit(addr_s, GRP_CLOCK);
      prn_rd_q <= io_rd_s && port_hit(addr_s, GRP_PRINTER);
      dsk_rd_q <= io_rd_s && port_hit(addr_s, GRP_DISK);
      sub_q    <= addr_s[SUB_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // clock interrupt
  // ----------------------------------------------------------------
  xdc_tick_if tick_bus ();

  xdc_tick_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clock    (clock),
    .nrst     (nrst),
    .ce       (ce),
    .tick_bus (tick_bus)
  );

  logic pend_q;
  logic clk_rd_first;
  logic [DATA_W-1:0] rd_data_q;

  // clear only once per read, on its first cycle
  assign clk_rd_first = io_rd_s && port_hit(addr_s, GRP_CLOCK) && !clk_rd_q;

  // a tick in the clearing cycle survives
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pend_q <= 1'b0;
    end else if (ce) begin
      if (tick_bus.tick) begin
        pend_q <= 1'b1;
      end else if (clk_rd_first) begin
        pend_q <= 1'b0;
      end
    end
  end

  // status byte latched when the read begins, pending before it clears
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rd_data_q <= DATA_RST;
    end else if (ce && clk_rd_first) begin
      rd_data_q               <= DATA_RST;
      rd_data_q[CLK_PEND_BIT] <= pend_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign host_data_out     = rd_data_q;
  assign host_data_oe_n    = !clk_rd_q;   // drives only for the clock status port
  assign host_nmi_n        = !pend_q;
  assign drive_select_wr   = drv_wr_q;
  assign printer_data_wr   = prn_wr_q;
  assign printer_status_rd = prn_rd_q;
  assign disk_wr           = dsk_wr_q;
  assign disk_rd           = dsk_rd_q;
  assign disk_sub_addr     = sub_q;
  assign lower_bank_enable = lower_en_q;
  assign upper_bank_enable = upper_en_q;
  assign dram_addr         = dram_addr_q;
  assign dram_ras_n        = ras_n_q;
  assign dram_cas_n        = cas_n_q;
  assign row_col_select    = sel_q;
  assign dram_we_n         = we_n_q;
  assign mem_read_enable   = rd_en_q;
  assign refresh_late      = late_q;

endmodule

// file: rtl/xdc_pkg.sv
// constants, field layouts and state codes for the expansion decode and memory control block
package xdc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ            = 100_000_000;
  localparam int TICK_MS           = 25;                          // clock interrupt period
  localparam int TICK_CYC          = (CLK_HZ / 1000) * TICK_MS;   // 2,500,000 cycles
  localparam int TICK_CNT_W        = 22;
  localparam int REFRESH_WINDOW_US = 2000;                        // every row within this window
  localparam int REFRESH_ROWS      = 128;
  // longest gap between two refresh pulses, rounded down
  localparam int REFRESH_GAP_CYC   = ((CLK_HZ / 1_000_000) * REFRESH_WINDOW_US) / REFRESH_ROWS;
  localparam int REFRESH_CNT_W     = 12;

  // ----------------------------------------------------------------
  // host address layout
  // ----------------------------------------------------------------
  localparam int ADDR_W        = 16;
  localparam int ADDR_MEM_BIT  = 15;           // set for 8000..FFFF
  localparam int ADDR_BANK_BIT = 14;           // clear 8000..BFFF, set C000..FFFF
  localparam int ROW_W         = 7;
  localparam int ROW_LSB       = 0;
  localparam int COL_LSB       = 7;
  localparam int GRP_LSB       = 2;            // port group field addr[3:2]
  localparam int SUB_LSB       = 0;            // disk sub-address addr[1:0]

  localparam logic [ADDR_W-1:0] PORT_BASE = 16'h37E0;
  localparam logic [ADDR_W-1:0] PORT_MASK = 16'hFFF0;

  localparam logic [1:0] GRP_CLOCK   = 2'h0;   // 37E0: drive select out, clock status in
  localparam logic [1:0] GRP_UNUSED  = 2'h1;   // 37E4
  localparam logic [1:0] GRP_PRINTER = 2'h2;   // 37E8
  localparam logic [1:0] GRP_DISK    = 2'h3;   // 37EC..37EF

  // ----------------------------------------------------------------
  // host data and status
  // ----------------------------------------------------------------
  localparam int          DATA_W        = 8;
  localparam int          CLK_PEND_BIT  = 7;
  localparam logic [7:0]  DATA_RST      = 8'h00;

  // ----------------------------------------------------------------
  // pin synchroniser: {addr, mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, rfsh_n}
  // ----------------------------------------------------------------
  localparam int              SYNC_W   = ADDR_W + 5;
  localparam logic [SYNC_W-1:0] SYNC_RST = {16'h0000, 5'h1F};

  // ----------------------------------------------------------------
  // memory sequencer states, gray along idle-row-col-cas-end
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_ROW     = 3'h1,
    ST_COL_SEL = 3'h3,
    ST_CAS     = 3'h2,
    ST_END     = 3'h6,
    ST_RFSH    = 3'h4
  } xdc_state_type;

endpackage

// file: rtl/xdc_tick_if.sv
// carrier for the periodic tick between the clock timer and the decoder core
`timescale 1ns/100ps
interface xdc_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input  tick);
endinterface

// file: rtl/xdc_tick_timer.sv
// free running divider giving one tick pulse per clock interrupt period
`timescale 1ns/100ps
module xdc_tick_timer #(
  parameter int TICK_CYCLES = xdc_pkg::TICK_CYC
) (
  input  wire logic  clock,
  input  wire logic  nrst,
  input  wire logic  ce,
  xdc_tick_if.src    tick_bus
);
  import xdc_pkg::*;

  logic [TICK_CNT_W-1:0] cnt_q;
  logic                  tick_q;

  // ----------------------------------------------------------------
  // period counter
  // ----------------------------------------------------------------
  // tick lasts one enabled cycle at the wrap
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      if (cnt_q == TICK_CNT_W'(TICK_CYCLES - 1)) begin
        cnt_q  <= '0;
        tick_q <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + TICK_CNT_W'(1);
        tick_q <= 1'b0;
      end
    end
  end

  assign tick_bus.tick = tick_q;

endmodule

// file: sim/expansion_decode_dram_control_bench.sv
// self-checking bench for the expansion decode and memory control core
`timescale 1ns/100ps
module expansion_decode_dram_control_bench;
  import xdc_pkg::*;
  localparam int TICKS = 50; // short interrupt period for simulation
  logic        clock, nrst, ce;
  logic [15:0] host_addr, rnd;
  logic        host_mem_rd_n, host_mem_wr_n, host_io_rd_n, host_io_wr_n, host_rfsh_n;
  logic [7:0]  host_data_out;
  logic [6:0]  dram_addr;
  logic [1:0]  dram_ras_n, disk_sub_addr;
  logic        host_data_oe_n, host_nmi_n, drive_select_wr, printer_data_wr, printer_status_rd, disk_wr, disk_rd;
  logic        lower_bank_enable, upper_bank_enable, dram_cas_n, row_col_select, dram_we_n, mem_read_enable;
  logic        refresh_late;
  int          error_cnt, samples_checked;
  logic [15:0] bnd [6] = '{16'h8000, 16'hBFFF, 16'hC000, 16'hFFFF, 16'h7FFF, 16'h0000};

  xdc_core #(.TICK_CYCLES(TICKS)) xdc_core_inst (.clock, .nrst, .ce, .host_addr, .host_mem_rd_n, .host_mem_wr_n,
    .host_io_rd_n, .host_io_wr_n, .host_rfsh_n, .host_data_out, .host_data_oe_n, .host_nmi_n, .drive_select_wr,
    .printer_data_wr, .printer_status_rd, .disk_wr, .disk_rd, .disk_sub_addr, .lower_bank_enable,
    .upper_bank_enable, .dram_addr, .dram_ras_n, .dram_cas_n, .row_col_select, .dram_we_n, .mem_read_enable,
    .refresh_late);
  xdc_host_model xdc_host_model_inst (.clock, .host_addr, .host_mem_rd_n, .host_mem_wr_n, .host_io_rd_n,
    .host_io_wr_n, .host_rfsh_n);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // sample away from the edge so the edge's updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  // bounded wait for a row strobe (sel 0) or an interrupt request (sel 1)
  task automatic wait_for(input logic sel);
    int i;
    for (i = 0; i < 2 * TICKS && (sel ? host_nmi_n !== 1'b0 : dram_ras_n === 2'b11); i++) step(1);
    if (i == 2 * TICKS) begin
      error_cnt++;
      complete_run();
    end
  endtask
  // one host memory cycle; unclaimed addresses must leave the memory alone
  task automatic mem_cycle(input logic [15:0] a, input logic wr);
    xdc_host_model_inst.drive(a, wr ? 5'h17 : 5'h0F);
    if (a[15]) begin
      wait_for(1'b0);
      check(dram_ras_n, a[14] ? 2'b01 : 2'b10);
      check({lower_bank_enable, upper_bank_enable}, {!a[14], a[14]});
      check({row_col_select, dram_addr, dram_we_n}, {1'b0, a[6:0], !wr});
      step(1);
      check({row_col_select, dram_addr, dram_cas_n}, {1'b1, a[13:7], 1'b1});
      step(1);
      check({dram_cas_n, mem_read_enable}, {1'b0, !wr});
    end else begin
      step(8);
      check({dram_ras_n, lower_bank_enable, upper_bank_enable}, 4'hC);
    end
    xdc_host_model_inst.release_bus();
    step(6);
    check({dram_ras_n, dram_cas_n, mem_read_enable}, 4'hE);
  endtask
  // refresh reaches both banks with the row only
  task automatic refresh(input logic [6:0] row);
    xdc_host_model_inst.refresh_fetch({1'b1, rnd[7:0], row});
    wait_for(1'b0);
    check({dram_ras_n, dram_cas_n, row_col_select, dram_addr}, {4'h2, row});
    check({lower_bank_enable, upper_bank_enable, mem_read_enable}, 3'h0);
    xdc_host_model_inst.release_bus();
    step(6);
    check({dram_ras_n, refresh_late}, 3'h6);
  endtask
  // io cycle with the expected strobe set worked out from the port map
  task automatic io_cycle(input logic [15:0] a, input logic wr);
    logic [1:0] g;
    logic       hit;
    g = a[3:2];
    hit = (a[15:4] == 12'h37E);
    xdc_host_model_inst.drive(a, wr ? 5'h1D : 5'h1B);
    step(5);
    check({drive_select_wr, printer_data_wr, disk_wr}, {hit && wr && g == 0, hit && wr && g == 2, hit && wr && g == 3});
    check({host_data_oe_n, printer_status_rd, disk_rd}, {!(hit && !wr && g == 0), hit && !wr && g == 2, hit && !wr && g == 3});
    if (hit && g == 3) check(disk_sub_addr, a[1:0]);
    xdc_host_model_inst.release_bus();
    step(5);
  endtask

  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    time t0;
    int  n;
    error_cnt = 0;
    samples_checked = 0;
    rnd = 16'h000C;
    nrst = 1'b0;
    ce = 1'b1;
    repeat (12) @(posedge clock);
    #1 nrst = 1'b1;
    step(2);
    for (int i = 0; i < 6; i++) mem_cycle(bnd[i], i[0]);
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr_step(rnd);
      mem_cycle(rnd, rnd[3]);
    end
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr_step(rnd);
      refresh(rnd[6:0]);
    end
    for (int i = 0; i < 18; i++) io_cycle(16'h37E0 + 16'(i), 1'b1);
    for (int i = 0; i < 18; i++) io_cycle(16'h37E0 + 16'(i), 1'b0);
    // pending request held long past its tick, cleared by the status read
    check(host_nmi_n, 1'b0);
    io_cycle(16'h37E0, 1'b0);
    check(host_data_out, 8'h80);
    // the first wait may land late if a tick beat the clear, so clear once more and time from a clean fall
    wait_for(1'b1);
    io_cycle(16'h37E0, 1'b0);
    wait_for(1'b1);
    t0 = $time;
    io_cycle(16'h37E0, 1'b0);
    io_cycle(16'h37E0, 1'b0);
    check({host_data_out, host_nmi_n}, 9'h001);
    wait_for(1'b1);
    check(16'(($time - t0) / 10), 16'(TICKS));
    // a held clock enable stops the interrupt timer
    io_cycle(16'h37E0, 1'b0);
    @(posedge clock);
    #1 ce = 1'b0;
    step(3 * TICKS);
    check(host_nmi_n, 1'b1);
    @(posedge clock);
    #1 ce = 1'b1;
    // no further refresh: the gap watchdog must trip near the row interval
    refresh(7'h7F);
    for (n = 0; n < 2000 && refresh_late !== 1'b1; n++) step(1);
    check(n inside {[1530:1562]}, 1'b1);
    complete_run();
  end
endmodule

// file: sim/xdc_core_checker.sv
// concurrent checks on the port behaviour of the expansion core
`timescale 1ns/100ps
module xdc_core_checker (
  input wire logic                       clock,
  input wire logic                       nrst,
  input wire logic                       ce,
  input wire logic                       host_mem_rd_n,
  input wire logic                       host_mem_wr_n,
  input wire logic                       host_io_wr_n,
  input wire logic [xdc_pkg::DATA_W-1:0] host_data_out,
  input wire logic                       host_data_oe_n,
  input wire logic                       host_nmi_n,
  input wire logic                       drive_select_wr,
  input wire logic                       printer_data_wr,
  input wire logic                       disk_wr,
  input wire logic                       lower_bank_enable,
  input wire logic                       upper_bank_enable,
  input wire logic [1:0]                 dram_ras_n,
  input wire logic                       dram_cas_n,
  input wire logic                       row_col_select,
  input wire logic                       dram_we_n,
  input wire logic                       mem_read_enable
);
  import xdc_pkg::*;
  // a low clock enable freezes every phase, so checks pause with it
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst || !ce);
  // ----------------------------------------------------------------
  // memory sequencing
  // ----------------------------------------------------------------
  sequence row_phase;
    !row_col_select && dram_cas_n;
  endsequence
  sequence col_phase;
    row_col_select && dram_cas_n ##1 !dram_cas_n;
  endsequence
  row_col_order_a: assert property (($fell(dram_ras_n[0]) ^ $fell(dram_ras_n[1])) |-> row_phase ##1 col_phase)
    else $error("row then column order broken");
  refresh_ras_only_a: assert property (dram_ras_n == 2'b00 |-> dram_cas_n && !row_col_select && !mem_read_enable)
    else $error("refresh drove more than row strobe");
  lower_bank_a: assert property (lower_bank_enable |-> dram_ras_n == 2'b10 && !upper_bank_enable)
    else $error("lower bank enable without its row strobe");
  upper_bank_a: assert property (upper_bank_enable |-> dram_ras_n == 2'b01 && !lower_bank_enable)
    else $error("upper bank enable without its row strobe");
  read_dir_a: assert property (mem_read_enable |-> !dram_cas_n && dram_we_n)
    else $error("read enable outside a read column phase");
  cas_after_col_a: assert property ($fell(dram_cas_n) |-> row_col_select && $past(row_col_select) && dram_ras_n != 2'b11)
    else $error("column strobe before column address");
  mem_idle_a: assert property ((host_mem_rd_n && host_mem_wr_n) [*6] |-> dram_cas_n && !lower_bank_enable && !upper_bank_enable)
    else $error("memory active with no host memory cycle");
  // ----------------------------------------------------------------
  // ports and clock interrupt
  // ----------------------------------------------------------------
  io_idle_a: assert property (host_io_wr_n [*4] |-> !drive_select_wr && !printer_data_wr && !disk_wr)
    else $error("write strobe with no host io write");
  nmi_clear_a: assert property ($rose(host_nmi_n) |-> !host_data_oe_n)
    else $error("interrupt cleared without a status read");
  status_byte_a: assert property ($fell(host_data_oe_n) |-> host_data_out == {!$past(host_nmi_n), 7'h00})
    else $error("status byte does not show pending flag");
endmodule

bind xdc_core xdc_core_checker xdc_core_checker_inst (.clock, .nrst, .ce, .host_mem_rd_n, .host_mem_wr_n,
  .host_io_wr_n, .host_data_out, .host_data_oe_n, .host_nmi_n, .drive_select_wr, .printer_data_wr, .disk_wr,
  .lower_bank_enable, .upper_bank_enable, .dram_ras_n, .dram_cas_n, .row_col_select, .dram_we_n, .mem_read_enable);

// file: sim/xdc_host_model.sv
// host bus model driving address, memory, io and refresh pins of the core
`timescale 1ns/100ps
module xdc_host_model (
  input  wire logic         clock,
  output logic [15:0]       host_addr,
  output logic              host_mem_rd_n,
  output logic              host_mem_wr_n,
  output logic              host_io_rd_n,
  output logic              host_io_wr_n,
  output logic              host_rfsh_n
);
  import xdc_pkg::*;
  // ----------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------
  // idle pins at time zero
  initial begin
    host_addr = 16'h0000;
    {host_mem_rd_n, host_mem_wr_n, host_io_rd_n, host_io_wr_n, host_rfsh_n} = 5'h1F;
  end
  // change just after an edge, hold until the next call; s = {mrd, mwr, iord, iowr, rfsh}
  task automatic drive(input logic [15:0] a, input logic [4:0] s);
    @(posedge clock);
    #1;
    host_addr = a;
    {host_mem_rd_n, host_mem_wr_n, host_io_rd_n, host_io_wr_n, host_rfsh_n} = s;
  endtask
  // released bus floats: shown as the inverse of the last address, not a stale copy
  task automatic release_bus();
    drive(~host_addr, 5'h1F);
  endtask
  // opcode fetch refresh: row on the bus, memory read and refresh low together
  task automatic refresh_fetch(input logic [15:0] a);
    drive(a, 5'h0E);
  endtask
endmodule
